// ### rtl/fas_pkg.sv
// Function
// RL1: flash reads are checked by a correcting code and single-bit errors corrected.
// RL2: a multi-bit flash error or any RAM error raises a security alarm.
// RL3: a detection value over the read-only memory is held and checked.
// RL4: a new flash page is verified before it is marked valid; the old page stays valid till then.
// RL5: a probing detector stops instruction processing at once and enters the security reset.
// RL6: two watchdog timers with checkpoint registers check processing time and program flow.
// RL7: a hash over executed instructions is checked and an illegal path raises an alarm.
// RL8: the symmetric coprocessor result is recomputed backwards; a mismatch is a fault.
// RL9: after startup software may run a self-test of alarm lines and sensors at any time.
// RL10: a temperature, glitch or light alarm enters the secure state and the internal reset.
// RL11: configuration and subsystem tests run at every startup before the self-test is allowed.
// RL12: every alarm is latched in one reset request held until the internal reset completes.
// RL13: a failed authentication code comparison causes a direct security reset.
package fas_pkg;

    // ********
    // widths
    // ********
    localparam int DATA_W  = 32;
    localparam int ECC_W   = 7;
    localparam int SYN_W   = 6;
    localparam int CODE_W  = 38;
    localparam int PAR_W   = 4;
    localparam int BYTE_W  = 8;
    localparam int SIG_W   = 32;
    localparam int CP_W    = 16;
    localparam int WCNT_W  = 16;
    localparam int ALARM_W = 14;
    localparam int IDX_W   = 4;
    localparam int CFG_W   = 8;
    localparam int NUM_WDG = 2;

    // ********
    // alarm line positions
    // ********
    localparam int AL_FLASH  = 0;
    localparam int AL_RAM    = 1;
    localparam int AL_ROM    = 2;
    localparam int AL_PROG   = 3;
    localparam int AL_PROBE  = 4;
    localparam int AL_WDG0   = 5;
    localparam int AL_WDG1   = 6;
    localparam int AL_FLOW   = 7;
    localparam int AL_SCP    = 8;
    localparam int AL_TEMP   = 9;
    localparam int AL_GLITCH = 10;
    localparam int AL_LIGHT  = 11;
    localparam int AL_AUTH   = 12;
    localparam int AL_TEST   = 13;

    // ********
    // timing and reset values
    // ********
    localparam int CLK_MHZ        = 125;
    localparam int CONFIG_TIME_NS = 1000;
    localparam int CONFIG_CYC     = (CONFIG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int WDG_TIME_US    = 100;
    localparam int WDG_CYC        = WDG_TIME_US * CLK_MHZ;
    localparam logic [SIG_W-1:0] SIG_SEED = 32'h5a5a_c3c3;
    localparam logic [SIG_W-1:0] ROM_SEED = 32'hffff_ffff;

    // ********
    // types
    // ********
    typedef enum logic [2:0] {
        ST_CONFIG   = 3'b000,
        ST_BIST     = 3'b001,
        ST_READY    = 3'b010,
        ST_SELFTEST = 3'b011,
        ST_SECURE   = 3'b100
    } fas_state_e;

    typedef enum logic [1:0] {
        PG_IDLE   = 2'b00,
        PG_WRITE  = 2'b01,
        PG_VERIFY = 2'b10
    } fas_pg_e;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
        logic [ECC_W-1:0]  check;
    } fas_flash_rd_s;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
        logic              corrected;
        logic              uncorrectable;
    } fas_flash_out_s;

    typedef struct packed {
        logic            enable;
        logic            cp_load;
        logic [CP_W-1:0] cp_value;
        logic            kick;
        logic [CP_W-1:0] kick_value;
    } fas_wdog_req_s;

    typedef struct packed {
        logic [CP_W-1:0]   cp;
        logic [WCNT_W-1:0] cnt;
        logic              alarm;
    } fas_wdog_s;

    typedef struct packed {
        fas_state_e         st;
        fas_pg_e            pg;
        logic [ALARM_W-1:0] line;
        logic [ALARM_W-1:0] inj;
        logic [ALARM_W-1:0] cause;
        logic               rst_req;
        logic               halt;
        logic [IDX_W-1:0]   idx;
        logic               phase;
        logic [CFG_W-1:0]   cfg_cnt;
        logic [SIG_W-1:0]   sig;
        logic [SIG_W-1:0]   rom;
        logic               pg_commit;
        logic               st_done;
        logic               st_pass;
    } fas_top_s;

endpackage

// ### rtl/fas_secded.sv
`timescale 1ns/10ps
module fas_secded
    import fas_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  fas_flash_rd_s rd,
    output fas_flash_out_s out
);

    fas_flash_out_s s_q;
    fas_flash_out_s s_d;

    // data fills the non power-of-two positions, check bits the others
    function automatic logic [CODE_W:1] place(logic [DATA_W-1:0] d, logic [ECC_W-1:0] c);
        logic [CODE_W:1] w;
        int j;
        int k;
        j = 0;
        k = 0;
        w = '0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) == 0) begin
                w[p] = c[k];
                k++;
            end else begin
                w[p] = d[j];
                j++;
            end
        end
        return w;
    endfunction

    function automatic logic [DATA_W-1:0] extract(logic [CODE_W:1] w);
        logic [DATA_W-1:0] d;
        int j;
        j = 0;
        d = '0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[j] = w[p];
                j++;
            end
        end
        return d;
    endfunction

    always_comb begin
        logic [CODE_W:1]  w;
        logic [SYN_W-1:0] syn;
        logic             perr;
        w    = place(rd.data, rd.check);
        syn  = '0;
        for (int p = 1; p <= CODE_W; p++) begin
            if (w[p]) begin
                syn = syn ^ p[SYN_W-1:0];
            end
        end
        perr = ^{w, rd.check[ECC_W-1]};
        s_d  = '0;
        s_d.valid = rd.valid;
        if (syn != '0 && perr && int'(syn) <= CODE_W) begin
            w[syn] = ~w[syn]; // [RL1]
            s_d.corrected = rd.valid;
        end else if (syn == '0 && perr) begin
            s_d.corrected = rd.valid; // [RL1]
        end else if (syn != '0) begin
            s_d.uncorrectable = rd.valid; // [RL2]
        end
        s_d.data = extract(w);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out = s_q;

endmodule

// ### rtl/fas_wdog.sv
`timescale 1ns/10ps
module fas_wdog
    import fas_pkg::*;
#(
    parameter logic [WCNT_W-1:0] TIMEOUT = WCNT_W'(WDG_CYC)
)(
    input  wire logic    clk,
    input  wire logic    rst,
    input  fas_wdog_req_s req,
    output logic         alarm
);

    fas_wdog_s s_q;
    fas_wdog_s s_d;

    always_comb begin
        s_d       = s_q;
        s_d.alarm = 1'b0;
        if (req.cp_load) begin
            s_d.cp = req.cp_value;
        end
        if (!req.enable) begin
            s_d.cnt = TIMEOUT;
        end else if (req.kick) begin
            // a wrong checkpoint means the flow took another path
            s_d.alarm = (req.kick_value != s_q.cp); // [RL6]
            s_d.cnt   = TIMEOUT;
        end else if (s_q.cnt == '0) begin
            s_d.alarm = 1'b1; // [RL6]
            s_d.cnt   = TIMEOUT;
        end else begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{cp: '0, cnt: '1, alarm: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign alarm = s_q.alarm;

endmodule

// ### rtl/fas_top.sv
`timescale 1ns/10ps
module fas_top
    import fas_pkg::*;
#(
    parameter int               WDG_TIMEOUT = WDG_CYC,
    parameter logic [SIG_W-1:0] ROM_EDC_REF = 32'h0000_0000
)(
    input  wire logic                 CLOCK,
    input  wire logic                 SYS_RST,
    input  fas_flash_rd_s             FL_RD,
    output fas_flash_out_s            FL_OUT,
    input  wire logic                 RAM_RD_VALID,
    input  wire logic [DATA_W-1:0]    RAM_RD_DATA,
    input  wire logic [PAR_W-1:0]     RAM_RD_PARITY,
    input  wire logic                 ROM_SCAN_VALID,
    input  wire logic [DATA_W-1:0]    ROM_SCAN_DATA,
    input  wire logic                 ROM_SCAN_LAST,
    input  wire logic                 PG_START,
    input  wire logic                 PG_WRITE_DONE,
    input  wire logic                 PG_VERIFY_DONE,
    input  wire logic                 PG_VERIFY_OK,
    output logic                      PG_BUSY,
    output logic                      PG_VERIFY_REQ,
    output logic                      PG_COMMIT,
    input  wire logic                 PROBE_DET,
    input  wire logic                 TEMP_ALARM,
    input  wire logic                 GLITCH_ALARM,
    input  wire logic                 LIGHT_ALARM,
    input  fas_wdog_req_s [NUM_WDG-1:0] WDG_REQ,
    input  wire logic                 INSTR_VALID,
    input  wire logic [SIG_W-1:0]     INSTR_WORD,
    input  wire logic                 FLOW_CHECK,
    input  wire logic [SIG_W-1:0]     FLOW_EXPECT,
    input  wire logic                 SCP_RESULT_VALID,
    input  wire logic [DATA_W-1:0]    SCP_INPUT,
    input  wire logic [DATA_W-1:0]    SCP_BACKWARD,
    input  wire logic                 AUTH_CMP_VALID,
    input  wire logic                 AUTH_CMP_OK,
    input  wire logic                 SELFTEST_REQ,
    output logic                      SELFTEST_BUSY,
    output logic                      SELFTEST_DONE,
    output logic                      SELFTEST_PASS,
    output logic                      STARTUP_DONE,
    input  wire logic                 RST_DONE,
    output logic                      CHIP_RST_REQ,
    output logic                      SECURE_STATE,
    output logic                      CPU_HALT,
    output logic [ALARM_W-1:0]        ALARM_CAUSE
);

    fas_top_s           s_q;
    fas_top_s           s_d;
    logic [NUM_WDG-1:0] wdog_alarm;
    logic [ALARM_W-1:0] raw;
    logic               ram_err;
    logic               sensor_hit;

    // ********
    // flash correction and watchdogs
    // ********
    fas_secded u_secded (
        .clk (CLOCK),
        .rst (SYS_RST),
        .rd  (FL_RD),
        .out (FL_OUT)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_WDG; g++) begin : g_wdog
            fas_wdog #(
                .TIMEOUT (WCNT_W'(WDG_TIMEOUT))
            ) u_wdog (
                .clk   (CLOCK),
                .rst   (SYS_RST),
                .req   (WDG_REQ[g]),
                .alarm (wdog_alarm[g]) // [RL6]
            );
        end
    endgenerate

    // ********
    // raw alarm lines
    // ********
    always_comb begin
        ram_err = 1'b0;
        for (int b = 0; b < PAR_W; b++) begin
            ram_err = ram_err | ((^RAM_RD_DATA[b*BYTE_W +: BYTE_W]) != RAM_RD_PARITY[b]);
        end
    end

    // sensors halt the core combinationally; a register stage would let one more instruction run
    assign sensor_hit = PROBE_DET | TEMP_ALARM | GLITCH_ALARM | LIGHT_ALARM;

    always_comb begin
        raw            = '0;
        raw[AL_FLASH]  = FL_OUT.valid & FL_OUT.uncorrectable; // [RL2]
        raw[AL_RAM]    = RAM_RD_VALID & ram_err; // [RL2]
        raw[AL_ROM]    = ROM_SCAN_VALID & ROM_SCAN_LAST & ((s_q.rom ^ ROM_SCAN_DATA) != ROM_EDC_REF); // [RL3]
        raw[AL_PROG]   = (s_q.pg == PG_VERIFY) & PG_VERIFY_DONE & ~PG_VERIFY_OK;
        raw[AL_PROBE]  = PROBE_DET; // [RL5]
        raw[AL_WDG0]   = wdog_alarm[0];
        raw[AL_WDG1]   = wdog_alarm[1];
        raw[AL_FLOW]   = FLOW_CHECK & (s_q.sig != FLOW_EXPECT); // [RL7]
        raw[AL_SCP]    = SCP_RESULT_VALID & (SCP_INPUT != SCP_BACKWARD); // [RL8]
        raw[AL_TEMP]   = TEMP_ALARM; // [RL10]
        raw[AL_GLITCH] = GLITCH_ALARM; // [RL10]
        raw[AL_LIGHT]  = LIGHT_ALARM; // [RL10]
        raw[AL_AUTH]   = AUTH_CMP_VALID & ~AUTH_CMP_OK; // [RL13]
    end

    // ********
    // next state
    // ********
    always_comb begin
        logic in_test;
        logic real_alarm;
        in_test    = (s_q.st == ST_BIST) || (s_q.st == ST_SELFTEST);
        real_alarm = |(s_q.line & ~s_q.inj);
        s_d           = s_q;
        s_d.pg_commit = 1'b0;
        s_d.st_done   = 1'b0;
        s_d.inj       = '0;
        if (in_test && !s_q.phase) begin
            s_d.inj[s_q.idx] = 1'b1; // [RL9]
        end
        s_d.line = raw | s_d.inj;

        // instruction hash, restarted at every check
        if (FLOW_CHECK) begin
            s_d.sig = INSTR_VALID ? (SIG_SEED ^ INSTR_WORD) : SIG_SEED;       // [RL7]
        end else if (INSTR_VALID) begin
            s_d.sig = {s_q.sig[SIG_W-2:0], s_q.sig[SIG_W-1]} ^ INSTR_WORD;    // [RL7]
        end

        if (ROM_SCAN_VALID) begin
            s_d.rom = ROM_SCAN_LAST ? ROM_SEED : ({s_q.rom[SIG_W-2:0], s_q.rom[SIG_W-1]} ^ ROM_SCAN_DATA); // [RL3]
        end

        // old page stays live until the verify passes and commit is pulsed
        case (s_q.pg)
            PG_IDLE: begin
                if (PG_START) begin
                    s_d.pg = PG_WRITE;
                end
            end
            PG_WRITE: begin
                if (PG_WRITE_DONE) begin
                    s_d.pg = PG_VERIFY;
                end
            end
            PG_VERIFY: begin
                if (PG_VERIFY_DONE) begin
                    s_d.pg        = PG_IDLE;
                    s_d.pg_commit = PG_VERIFY_OK; // [RL4]
                end
            end
            default: begin
                s_d.pg = PG_IDLE;
            end
        endcase

        case (s_q.st)
            ST_CONFIG: begin
                if (s_q.cfg_cnt == CFG_W'(CONFIG_CYC - 1)) begin
                    s_d.st    = ST_BIST; // [RL11]
                    s_d.idx   = '0;
                    s_d.phase = 1'b0;
                end else begin
                    s_d.cfg_cnt = s_q.cfg_cnt + 1'b1;
                end
            end
            ST_BIST, ST_SELFTEST: begin
                s_d.phase = ~s_q.phase;
                if (s_q.phase) begin
                    if (!s_q.line[s_q.idx]) begin
                        s_d.cause[AL_TEST] = 1'b1; // [RL9]
                        s_d.st_done        = (s_q.st == ST_SELFTEST);
                        s_d.st_pass        = 1'b0;
                        s_d.rst_req        = 1'b1;
                        s_d.halt           = 1'b1;
                        s_d.st             = ST_SECURE;
                    end else if (s_q.idx == IDX_W'(ALARM_W - 1)) begin
                        s_d.st_done = (s_q.st == ST_SELFTEST);
                        s_d.st_pass = 1'b1;
                        s_d.st      = ST_READY; // [RL11]
                    end else begin
                        s_d.idx = s_q.idx + 1'b1;
                    end
                end
            end
            ST_READY: begin
                if (SELFTEST_REQ) begin
                    s_d.st      = ST_SELFTEST; // [RL9]
                    s_d.idx     = '0;
                    s_d.phase   = 1'b0;
                    s_d.st_pass = 1'b0;
                end
            end
            ST_SECURE: begin
                if (s_q.rst_req && RST_DONE) begin
                    s_d.rst_req = 1'b0; // [RL12]
                    s_d.halt    = 1'b0;
                    s_d.cause   = '0;
                    s_d.cfg_cnt = '0;
                    s_d.st      = ST_CONFIG;
                end
            end
            default: begin
                s_d.st = ST_SECURE;
            end
        endcase

        // a real alarm overrides any test or startup step
        if (real_alarm && s_q.st != ST_SECURE) begin
            s_d.cause   = s_q.cause | (s_q.line & ~s_q.inj); // [RL12]
            s_d.rst_req = 1'b1; // [RL10]
            s_d.halt    = 1'b1; // [RL5]
            s_d.st_done = (s_q.st == ST_SELFTEST);
            s_d.st_pass = 1'b0;
            s_d.st      = ST_SECURE;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q <= '{st: ST_CONFIG, pg: PG_IDLE, sig: SIG_SEED, rom: ROM_SEED, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ********
    // outputs
    // ********
    assign PG_BUSY       = (s_q.pg != PG_IDLE);
    assign PG_VERIFY_REQ = (s_q.pg == PG_VERIFY);
    assign PG_COMMIT     = s_q.pg_commit;
    assign SELFTEST_BUSY = (s_q.st == ST_SELFTEST);
    assign SELFTEST_DONE = s_q.st_done;
    assign SELFTEST_PASS = s_q.st_pass;
    assign STARTUP_DONE  = (s_q.st == ST_READY) || (s_q.st == ST_SELFTEST);
    assign CHIP_RST_REQ  = s_q.rst_req; // [RL12]
    assign SECURE_STATE  = (s_q.st == ST_SECURE);
    assign CPU_HALT      = s_q.halt | sensor_hit; // [RL5]
    assign ALARM_CAUSE   = s_q.cause;

endmodule

// ### verification/fas_top_asserts.sv
`timescale 1ns/10ps
module fas_top_asserts
    import fas_pkg::*;
(
    input wire logic           CLOCK,
    input wire logic           SYS_RST,
    input fas_flash_rd_s       FL_RD,
    input fas_flash_out_s      FL_OUT,
    input wire logic           RAM_RD_VALID,
    input wire logic [DATA_W-1:0] RAM_RD_DATA,
    input wire logic [PAR_W-1:0]  RAM_RD_PARITY,
    input wire logic           PROBE_DET,
    input wire logic           TEMP_ALARM,
    input wire logic           GLITCH_ALARM,
    input wire logic           LIGHT_ALARM,
    input wire logic           PG_VERIFY_REQ,
    input wire logic           PG_VERIFY_DONE,
    input wire logic           PG_VERIFY_OK,
    input wire logic           PG_COMMIT,
    input wire logic           AUTH_CMP_VALID,
    input wire logic           AUTH_CMP_OK,
    input wire logic           SELFTEST_BUSY,
    input wire logic           STARTUP_DONE,
    input wire logic           RST_DONE,
    input wire logic           CHIP_RST_REQ,
    input wire logic           SECURE_STATE,
    input wire logic           CPU_HALT,
    input wire logic [ALARM_W-1:0] ALARM_CAUSE
);
    // ********
    // alarm and reset checks
    // ********
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    logic sens;
    logic ram_bad;
    assign sens = TEMP_ALARM | GLITCH_ALARM | LIGHT_ALARM | PROBE_DET;
    assign ram_bad = RAM_RD_VALID && (RAM_RD_PARITY != {^RAM_RD_DATA[31:24], ^RAM_RD_DATA[23:16],
        ^RAM_RD_DATA[15:8], ^RAM_RD_DATA[7:0]});
    halt_on_sensor_a: assert property (sens |-> CPU_HALT)
        else $error("cpu not halted by sensor");
    sensor_reset_a: assert property (sens && !CHIP_RST_REQ |-> ##2 CHIP_RST_REQ && SECURE_STATE)
        else $error("sensor did not start reset");
    request_holds_a: assert property (CHIP_RST_REQ && !RST_DONE |=> CHIP_RST_REQ)
        else $error("reset request dropped early");
    request_clears_a: assert property (CHIP_RST_REQ && RST_DONE |=> !CHIP_RST_REQ && !STARTUP_DONE)
        else $error("reset request not released");
    flash_answer_a: assert property (FL_RD.valid |=> FL_OUT.valid)
        else $error("flash word not answered");
    flash_alarm_a: assert property (FL_OUT.valid && FL_OUT.uncorrectable && !CHIP_RST_REQ
        |-> ##[1:3] ALARM_CAUSE[AL_FLASH])
        else $error("flash double error not alarmed");
    ram_alarm_a: assert property (ram_bad && !CHIP_RST_REQ |-> ##2 ALARM_CAUSE[AL_RAM])
        else $error("ram error not alarmed");
    commit_after_verify_a: assert property (PG_COMMIT |-> $past(PG_VERIFY_REQ && PG_VERIFY_DONE && PG_VERIFY_OK))
        else $error("page committed without verify");
    test_after_start_a: assert property ($rose(SELFTEST_BUSY) |-> $past(STARTUP_DONE))
        else $error("self test before startup");
    auth_reset_a: assert property (AUTH_CMP_VALID && !AUTH_CMP_OK && !CHIP_RST_REQ
        |-> ##2 CHIP_RST_REQ && ALARM_CAUSE[AL_AUTH])
        else $error("auth failure without reset");
endmodule

bind fas_top fas_top_asserts i_fas_top_asserts (.*);

// ### verification/fas_partner.sv
`timescale 1ns/10ps
module fas_partner (
    input  wire logic CLOCK,
    input  wire logic SYS_RST,
    input  wire logic verify_ok,
    input  wire logic PG_BUSY,
    input  wire logic PG_VERIFY_REQ,
    input  wire logic CHIP_RST_REQ,
    output logic      PG_WRITE_DONE,
    output logic      PG_VERIFY_DONE,
    output logic      PG_VERIFY_OK,
    output logic      RST_DONE
);
    // ********
    // page memory and reset sequencer
    // ********
    int wr_cnt, vf_cnt, rs_cnt;
    always @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            {PG_WRITE_DONE, PG_VERIFY_DONE, PG_VERIFY_OK, RST_DONE} <= 4'h0;
            {wr_cnt, vf_cnt, rs_cnt} <= '0;
        end else begin
            wr_cnt <= (PG_BUSY && !PG_VERIFY_REQ) ? wr_cnt + 1 : 0;
            vf_cnt <= PG_VERIFY_REQ ? vf_cnt + 1 : 0;
            rs_cnt <= CHIP_RST_REQ ? rs_cnt + 1 : 0;
            PG_WRITE_DONE  <= (wr_cnt == 3);
            PG_VERIFY_DONE <= (vf_cnt == 2);
            // inverted outside its pulse so a stale ok never passes
            PG_VERIFY_OK   <= (vf_cnt == 2) ? verify_ok : ~verify_ok;
            RST_DONE       <= (rs_cnt == 5);
        end
    end
endmodule

// ### verification/fas_top_test.sv
`timescale 1ns/10ps
module fas_top_test
    import fas_pkg::*;
;
    logic CLOCK, SYS_RST, verify_ok, RAM_RD_VALID, ROM_SCAN_VALID, ROM_SCAN_LAST, PG_START;
    logic PROBE_DET, TEMP_ALARM, GLITCH_ALARM, LIGHT_ALARM, INSTR_VALID, FLOW_CHECK;
    logic SCP_RESULT_VALID, AUTH_CMP_VALID, AUTH_CMP_OK, SELFTEST_REQ, PG_WRITE_DONE, PG_VERIFY_DONE;
    logic PG_VERIFY_OK, RST_DONE, PG_BUSY, PG_VERIFY_REQ, PG_COMMIT, SELFTEST_BUSY, SELFTEST_DONE;
    logic SELFTEST_PASS, STARTUP_DONE, CHIP_RST_REQ, SECURE_STATE, CPU_HALT;
    logic [DATA_W-1:0]           RAM_RD_DATA, ROM_SCAN_DATA, SCP_INPUT, SCP_BACKWARD;
    logic [SIG_W-1:0]            INSTR_WORD, FLOW_EXPECT;
    logic [PAR_W-1:0]            RAM_RD_PARITY;
    logic [ALARM_W-1:0]          ALARM_CAUSE;
    fas_flash_rd_s               FL_RD;
    fas_flash_out_s              FL_OUT;
    fas_wdog_req_s [NUM_WDG-1:0] WDG_REQ;
    int                          fails;
    int                          samples_checked;
    int                          al_list[] = '{AL_FLASH, AL_RAM, AL_ROM, AL_PROBE, AL_WDG0, AL_WDG1,
        AL_FLOW, AL_SCP, AL_TEMP, AL_GLITCH, AL_LIGHT, AL_AUTH};

    fas_top #(.WDG_TIMEOUT(20), .ROM_EDC_REF(32'hffff_ffff)) i_fas_top (.*);
    fas_partner i_fas_partner (.*);

    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end

    // ********
    // helpers
    // ********
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_hi(ref logic s, input int lim, input string what, output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge CLOCK);
            #1;
            if (s === 1'b1) return;
        end
        fails++;
        $display("unexpected %s: expected 1 seen %b", what, s);
        end_sim();
    endtask

    task automatic idle();
        {RAM_RD_VALID, ROM_SCAN_VALID, ROM_SCAN_LAST, PG_START, INSTR_VALID, FLOW_CHECK} <= '0;
        {PROBE_DET, TEMP_ALARM, GLITCH_ALARM, LIGHT_ALARM, SELFTEST_REQ} <= '0;
        {SCP_RESULT_VALID, AUTH_CMP_VALID, AUTH_CMP_OK} <= '0;
        {FL_RD, WDG_REQ, INSTR_WORD, FLOW_EXPECT, ROM_SCAN_DATA} <= '0;
        {RAM_RD_DATA, RAM_RD_PARITY} <= {32'h0000_0001, 4'h1};
        {SCP_INPUT, SCP_BACKWARD} <= {32'h0000_0001, 32'h0000_0002};
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_startup();
        int n;
        @(posedge CLOCK);
        SELFTEST_REQ <= 1'b1;
        @(posedge CLOCK);
        SELFTEST_REQ <= 1'b0;
        #1;
        chk("early self test", 0, SELFTEST_BUSY);
        wait_hi(STARTUP_DONE, 400, "startup done", n);
        chk("startup length", 1, n + 2 >= CONFIG_CYC + 2 * ALARM_W - 1 && n <= CONFIG_CYC + 2 * ALARM_W);
    endtask

    task automatic t_flow();
        logic [SIG_W-1:0] h;
        h = {SIG_SEED[SIG_W-2:0], SIG_SEED[SIG_W-1]} ^ 32'h1234_5678;
        @(posedge CLOCK);
        INSTR_VALID <= 1'b1;
        INSTR_WORD <= 32'h1234_5678;
        @(posedge CLOCK);
        INSTR_VALID <= 1'b0;
        FLOW_CHECK <= 1'b1;
        FLOW_EXPECT <= h;
        @(posedge CLOCK);
        FLOW_CHECK <= 1'b0;
        repeat (4) @(posedge CLOCK);
        chk("good flow reset", 0, CHIP_RST_REQ);
    endtask

    task automatic t_flash();
        @(posedge CLOCK);
        FL_RD <= '{1'b1, 32'h0000_0010, 7'h00};
        {ROM_SCAN_VALID, ROM_SCAN_LAST, RAM_RD_VALID} <= 3'h7;
        @(posedge CLOCK);
        FL_RD <= '{1'b1, 32'h0, 7'h00};
        {ROM_SCAN_VALID, ROM_SCAN_LAST, RAM_RD_VALID} <= 3'h0;
        #1;
        chk("flash fixed", {32'h0, 2'b10}, {FL_OUT.data, FL_OUT.corrected, FL_OUT.uncorrectable});
        @(posedge CLOCK);
        FL_RD <= '0;
        #1;
        chk("flash clean", {1'b1, 32'h0, 2'b00}, {FL_OUT.valid, FL_OUT.data, FL_OUT.corrected, FL_OUT.uncorrectable});
        repeat (4) @(posedge CLOCK);
        chk("clean reads reset", 0, CHIP_RST_REQ);
    endtask

    task automatic t_selftest();
        int n;
        @(posedge CLOCK);
        SELFTEST_REQ <= 1'b1;
        @(posedge CLOCK);
        SELFTEST_REQ <= 1'b0;
        #1;
        chk("self test busy", 1, SELFTEST_BUSY);
        wait_hi(SELFTEST_DONE, 100, "self test done", n);
        chk("self test pass", 2'b10, {SELFTEST_PASS, CHIP_RST_REQ});
    endtask

    task automatic t_page(input logic good);
        int n;
        @(posedge CLOCK);
        verify_ok <= good;
        PG_START <= 1'b1;
        @(posedge CLOCK);
        PG_START <= 1'b0;
        #1;
        chk("page busy", 1, PG_BUSY);
        wait_hi(PG_VERIFY_REQ, 20, "page verify", n);
        chk("commit before verify", 0, PG_COMMIT);
        if (good) begin
            wait_hi(PG_COMMIT, 20, "page commit", n);
        end else begin
            wait_hi(CHIP_RST_REQ, 20, "page alarm", n);
            chk("page cause", 1 << AL_PROG, ALARM_CAUSE);
            wait_hi(STARTUP_DONE, 400, "restart", n);
        end
    endtask

    task automatic fire(input int al);
        int n;
        @(posedge CLOCK);
        case (al)
            AL_FLASH: FL_RD <= '{1'b1, 32'h0000_0003, 7'h00};
            AL_RAM: {RAM_RD_VALID, RAM_RD_PARITY} <= 5'h10;
            AL_ROM: {ROM_SCAN_VALID, ROM_SCAN_LAST, ROM_SCAN_DATA} <= {2'b11, 32'h1};
            AL_PROBE: PROBE_DET <= 1'b1;
            AL_WDG0: WDG_REQ[0] <= '{1'b1, 1'b0, 16'h0, 1'b0, 16'h0};
            AL_WDG1: WDG_REQ[1] <= '{1'b1, 1'b1, 16'h5, 1'b0, 16'h0};
            AL_FLOW: FLOW_CHECK <= 1'b1;
            AL_SCP: SCP_RESULT_VALID <= 1'b1;
            AL_TEMP: TEMP_ALARM <= 1'b1;
            AL_GLITCH: GLITCH_ALARM <= 1'b1;
            AL_LIGHT: LIGHT_ALARM <= 1'b1;
            default: AUTH_CMP_VALID <= 1'b1;
        endcase
        @(posedge CLOCK);
        #1;
        if (al inside {AL_PROBE, AL_TEMP, AL_GLITCH, AL_LIGHT}) chk("cpu halt", 1, CPU_HALT);
        if (al == AL_WDG1) WDG_REQ[1] <= '{1'b1, 1'b0, 16'h5, 1'b1, 16'h6};
        if (al == AL_WDG1) @(posedge CLOCK);
        if (al != AL_WDG0) idle();
        wait_hi(CHIP_RST_REQ, 40, "reset request", n);
        chk("alarm cause", 1 << al, ALARM_CAUSE);
        chk("secure state", 1, SECURE_STATE);
        idle();
        wait_hi(STARTUP_DONE, 400, "restart", n);
    endtask

    initial begin
        fails = 0;
        samples_checked = 0;
        SYS_RST = 1'b1;
        verify_ok = 1'b1;
        idle();
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        t_startup();
        t_flow();
        t_flash();
        t_selftest();
        t_page(1'b1);
        t_page(1'b0);
        foreach (al_list[i]) fire(al_list[i]);
        end_sim();
    end
endmodule
